//--- src/div_counter.sv
// pulse-swallowing counter that produces the divided output pair
`timescale 1ns/100ps
`default_nettype none
module div_counter #(
  parameter int unsigned RATIO_W = 20
) (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic [RATIO_W-1:0] ratio,
  input  wire logic [2:0]         duty,
  output logic                    period_end,
  output logic                    out_true,
  output logic                    out_comp
);
  logic [RATIO_W-1:0] count_ff;
  logic [RATIO_W-1:0] ratio_ff;
  logic               comp_ff;

  // high time grows with the duty code, in whole input periods
  function automatic logic [RATIO_W-1:0] width_of(input logic [2:0] d);
    width_of = RATIO_W'({d, 1'b1});
  endfunction

  assign period_end = (count_ff == RATIO_W'(1));

  always_ff @(posedge clk) begin
    if (reset) begin
      count_ff <= RATIO_W'(32);
      ratio_ff <= RATIO_W'(32);
    end else if (period_end) begin
      count_ff <= ratio;
      ratio_ff <= ratio;
    end else begin
      count_ff <= count_ff - RATIO_W'(1);
    end
  end

  // rising edge of true output retimed on clk
  always_ff @(posedge clk) begin
    if (reset)
      out_true <= 1'b0;
    else if (period_end)
      out_true <= 1'b1;
    else if (ratio_ff - count_ff + RATIO_W'(1) >= width_of(duty))
      out_true <= 1'b0;
  end

  // complement falls retimed; its rise is also retimed, one clock after the true fall
  always_ff @(posedge clk) begin
    if (reset)
      comp_ff <= 1'b1;
    else
      comp_ff <= ~(period_end | out_true);
  end
  assign out_comp = comp_ff;
endmodule // div_counter
`default_nettype wire

//--- src/frac_div_pkg.sv
// shared constants and types for the fractional divider control block
package frac_div_pkg;
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 24;
  localparam int unsigned RATIO_W      = 20;
  localparam int unsigned CHIP_W       = 3;
  localparam int unsigned DUTY_W       = 3;
  localparam int unsigned OFFS_W       = 4;
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_REFDIV   = 8'h02;
  localparam logic [7:0]  REG_INT      = 8'h05;
  localparam logic [7:0]  REG_COMP     = 8'h09;
  localparam logic [7:0]  REG_MODE     = 8'h0a;
  localparam int unsigned DUTY_LSB     = 12;
  localparam int unsigned FRAC_EN_BIT  = 0;
  localparam logic [19:0] INT_MIN      = 20'h00020;
  localparam logic [19:0] INT_MAX      = 20'hfffff;
  localparam logic [19:0] FRAC_MIN     = 20'h00024;
  localparam logic [19:0] FRAC_MAX     = 20'hffffb;
  localparam logic [19:0] INT_RESET    = 20'h00064;
  localparam logic [2:0]  DUTY_RESET   = 3'h4;
  localparam logic [23:0] COMP_RESET   = 24'h000000;
  localparam logic [23:0] REFDIV_RESET = 24'h000001;

  // one decoded serial write as it reaches the register file
  typedef struct packed {
    logic              valid;
    logic [CHIP_W-1:0] chip;
    logic [7:0]        addr;
    logic [23:0]       data;
  } spi_wr_t;

  typedef struct packed {
    logic              frac_en;
    logic [2:0]        duty;
    logic [19:0]       n_int;
  } div_cfg_t;
endpackage : frac_div_pkg

//--- src/frac_divider_addr_snoop.sv
// register file, strap address, companion snooping and divider control
// What this block does
// - integer mode divides by any whole ratio from 32 to 1048575
// - fractional mode keeps instantaneous ratio within 36 to 1048571
// - pulse width in whole input periods from duty field ident_reset_duty_ctrl bits 14:12
// - both edges of the true and complement outputs are retimed
// - own address is msb strap, mid strap, lsb strap
// - straps latched at power-up and each reset, held until next reset
// - open strap reads one, grounded strap reads zero
// - register 09h stores the companion chip address
// - writes to companion address update our register 02h too
// - writes are taken only when they match our strap address, or the companion address for reg 02h
// - companion address equal to own address disables snooping
// - integer ratio comes from reg 05h bits 19:0
`timescale 1ns/100ps
`default_nettype none
module frac_divider_addr_snoop #(
  parameter int unsigned RATIO_W = frac_div_pkg::RATIO_W,
  parameter int unsigned OFFS_W  = frac_div_pkg::OFFS_W
) (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   addr_strap_lsb,
  input  wire logic                   addr_strap_mid,
  input  wire logic                   addr_strap_msb,
  input  wire frac_div_pkg::spi_wr_t  spi_wr,
  input  wire logic [7:0]             rd_addr,
  input  wire logic [OFFS_W-1:0]      dsm_offset,
  output logic [23:0]                 rd_data,
  output logic [2:0]                  own_addr,
  output logic                        ratio_err,
  output logic                        div_out_true,
  output logic                        div_out_comp
);
  logic [2:0]           own_addr_ff;
  logic                 strap_pending_ff;
  frac_div_pkg::div_cfg_t cfg_ff;
  logic [23:0]          comp_addr_ff;
  logic [23:0]          refdiv_ff;
  logic [RATIO_W-1:0]   nxt_ratio;
  logic [RATIO_W-1:0]   ratio_ff;
  logic                 ratio_err_ff;
  logic [23:0]          rd_data_ff;
  logic                 period_end;
  logic                 own_hit;
  logic                 comp_hit;
  logic                 true_raw;
  logic                 comp_raw;
  logic                 true_ff;
  logic                 comp_ff;

  // clamp a requested ratio into an allowed window
  function automatic logic [RATIO_W-1:0] clamp(
    input logic [RATIO_W:0] v,
    input logic [RATIO_W-1:0] lo,
    input logic [RATIO_W-1:0] hi
  );
    if (v < {1'b0, lo})
      clamp = lo;
    else if (v > {1'b0, hi})
      clamp = hi;
    else
      clamp = v[RATIO_W-1:0];
  endfunction

  // straps caught one clock after reset releases, never inside the reset
  always_ff @(posedge clk) begin
    if (reset) begin
      strap_pending_ff <= 1'b1;
      own_addr_ff      <= 3'h7;
    end else if (strap_pending_ff) begin
      strap_pending_ff <= 1'b0;
      // pads pull open straps high, so a floating pin arrives as one
      own_addr_ff <= {addr_strap_msb, addr_strap_mid, addr_strap_lsb};
    end
  end

  assign own_hit  = spi_wr.valid && !strap_pending_ff
                    && (spi_wr.chip == own_addr_ff);
  assign comp_hit = spi_wr.valid && !strap_pending_ff
                    && (comp_addr_ff[2:0] != own_addr_ff)
                    && (spi_wr.chip == comp_addr_ff[2:0]);

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_ff.frac_en <= 1'b0;
      cfg_ff.duty    <= frac_div_pkg::DUTY_RESET;
      cfg_ff.n_int   <= frac_div_pkg::INT_RESET;
    end else if (own_hit) begin
      if (spi_wr.addr == frac_div_pkg::REG_CTRL)
        cfg_ff.duty <= spi_wr.data[frac_div_pkg::DUTY_LSB +: 3];
      if (spi_wr.addr == frac_div_pkg::REG_INT)
        cfg_ff.n_int <= spi_wr.data[19:0];
      if (spi_wr.addr == frac_div_pkg::REG_MODE)
        cfg_ff.frac_en <= spi_wr.data[frac_div_pkg::FRAC_EN_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (reset)
      comp_addr_ff <= frac_div_pkg::COMP_RESET;
    else if (own_hit && spi_wr.addr == frac_div_pkg::REG_COMP)
      comp_addr_ff <= spi_wr.data;
  end

  // reference ratio follows writes to us or to the companion alike
  always_ff @(posedge clk) begin
    if (reset)
      refdiv_ff <= frac_div_pkg::REFDIV_RESET;
    else if ((own_hit || comp_hit)
             && spi_wr.addr == frac_div_pkg::REG_REFDIV)
      refdiv_ff <= spi_wr.data;
  end

  // next period ratio: integer part plus signed offset in fractional mode
  always_comb begin
    logic [RATIO_W:0] sum;
    sum = {1'b0, cfg_ff.n_int}
          + (RATIO_W+1)'(signed'(dsm_offset));
    if (cfg_ff.frac_en)
      nxt_ratio = clamp(sum, frac_div_pkg::FRAC_MIN,
                        frac_div_pkg::FRAC_MAX);
    else
      nxt_ratio = clamp({1'b0, cfg_ff.n_int}, frac_div_pkg::INT_MIN,
                        frac_div_pkg::INT_MAX);
  end

  // loaded once per output period so the counter never sees a mid change
  always_ff @(posedge clk) begin
    if (reset) begin
      ratio_ff     <= frac_div_pkg::INT_MIN;
      ratio_err_ff <= 1'b0;
    end else begin
      if (period_end)
        ratio_ff <= nxt_ratio;
      // flag tracks the programmed value at once; a long period would hide it
      ratio_err_ff <= cfg_ff.frac_en ?
        (cfg_ff.n_int < frac_div_pkg::FRAC_MIN
         || cfg_ff.n_int > frac_div_pkg::FRAC_MAX) :
        (cfg_ff.n_int < frac_div_pkg::INT_MIN);
    end
  end

  div_counter #(
    .RATIO_W (RATIO_W)
  ) u_count (
    .clk        (clk),
    .reset      (reset),
    .ratio      (ratio_ff),
    .duty       (cfg_ff.duty),
    .period_end (period_end),
    .out_true   (true_raw),
    .out_comp   (comp_raw)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      true_ff <= 1'b0;
      comp_ff <= 1'b1;
    end else begin
      true_ff <= true_raw;
      comp_ff <= comp_raw;
    end
  end

  always_ff @(posedge clk) begin
    if (reset)
      rd_data_ff <= 24'h000000;
    else begin
      unique case (rd_addr)
        frac_div_pkg::REG_CTRL:
          rd_data_ff <= {9'h000, cfg_ff.duty, 9'h000, own_addr_ff};
        frac_div_pkg::REG_REFDIV: rd_data_ff <= refdiv_ff;
        frac_div_pkg::REG_INT:    rd_data_ff <= {4'h0, cfg_ff.n_int};
        frac_div_pkg::REG_COMP:   rd_data_ff <= comp_addr_ff;
        frac_div_pkg::REG_MODE:   rd_data_ff <= {23'h000000, cfg_ff.frac_en};
        default:                  rd_data_ff <= 24'h000000;
      endcase
    end
  end

  assign rd_data      = rd_data_ff;
  assign own_addr     = own_addr_ff;
  assign ratio_err    = ratio_err_ff;
  assign div_out_true = true_ff;
  assign div_out_comp = comp_ff;
endmodule // frac_divider_addr_snoop
`default_nettype wire

//--- verif/frac_divider_addr_snoop_monitor.sv
// port assertions for the divider control block
`timescale 1ns/100ps
`default_nettype none
module frac_div_monitor (
  input wire logic                  clk,
  input wire logic                  reset,
  input wire logic                  addr_strap_lsb,
  input wire logic                  addr_strap_mid,
  input wire logic                  addr_strap_msb,
  input wire frac_div_pkg::spi_wr_t spi_wr,
  input wire logic [7:0]            rd_addr,
  input wire logic [23:0]           rd_data,
  input wire logic [2:0]            own_addr,
  input wire logic                  div_out_true,
  input wire logic                  div_out_comp
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_latch;
    $fell(reset) |=> own_addr ==
      $past({addr_strap_msb, addr_strap_mid, addr_strap_lsb});
  endproperty
  a_latch: assert property (p_latch) else $error("strap latch wrong");
  property p_hold;
    !$past(reset) && !$past(reset, 2) |-> $stable(own_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("own address moved");
  property p_rst;
    disable iff (1'b0) reset |=> own_addr == 3'h7 && rd_data == 24'h0 &&
      !div_out_true && div_out_comp;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_excl;
    div_out_true |-> !div_out_comp;
  endproperty
  a_excl: assert property (p_excl) else $error("outputs overlap");
  property p_tail;
    $fell(div_out_true) |-> !div_out_comp ##1 div_out_comp;
  endproperty
  a_tail: assert property (p_tail) else $error("comp tail wrong");
  property p_crise;
    $rose(div_out_comp) |-> $past(div_out_true, 2) && !$past(div_out_true);
  endproperty
  a_crise: assert property (p_crise) else $error("comp rise early");
  property p_ctrl;
    !$past(reset) && rd_addr == 8'h00 |=> rd_data[2:0] == own_addr;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("ctrl read wrong");
  property p_comp;
    spi_wr.valid && spi_wr.chip == own_addr && spi_wr.addr == 8'h09
      ##1 !spi_wr.valid ##1 rd_addr == 8'h09
      |=> rd_data == $past(spi_wr.data, 3);
  endproperty
  a_comp: assert property (p_comp) else $error("companion reg wrong");
  c_rise: cover property ($rose(div_out_true));
  c_other: cover property (spi_wr.valid && spi_wr.chip != own_addr);
  c_rel: cover property ($fell(reset));
endmodule // frac_div_monitor
bind frac_divider_addr_snoop frac_div_monitor mon (.clk(clk), .reset(reset),
  .addr_strap_lsb(addr_strap_lsb), .addr_strap_mid(addr_strap_mid),
  .addr_strap_msb(addr_strap_msb), .spi_wr(spi_wr), .rd_addr(rd_addr),
  .rd_data(rd_data), .own_addr(own_addr), .div_out_true(div_out_true),
  .div_out_comp(div_out_comp));
`default_nettype wire

//--- verif/frac_divider_addr_snoop_tb.sv
// self-checking bench for the divider control block
`timescale 1ns/100ps
`default_nettype none
module frac_divider_addr_snoop_tb;
  logic                  clk;
  logic                  reset;
  logic [2:0]            strap;
  logic [3:0]            dsm_offset;
  logic [23:0]           rd_data;
  logic [23:0]           got;
  logic [2:0]            own_addr;
  logic                  ratio_err;
  logic                  div_out_true;
  logic                  div_out_comp;
  logic [7:0]            rd_addr;
  frac_div_pkg::spi_wr_t spi_wr;
  int                    num_errors;
  int                    n_tests;
  logic [19:0]           ni[5] = '{20'h1f, 20'hfffff, 20'h23, 20'hffffc, 20'h24};
  logic                  fe[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  logic                  er[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  serial_host_model host (.clk(clk), .spi_wr(spi_wr), .rd_addr(rd_addr),
    .rd_data(rd_data));
  frac_divider_addr_snoop dut (.clk(clk), .reset(reset),
    .addr_strap_lsb(strap[0]), .addr_strap_mid(strap[1]),
    .addr_strap_msb(strap[2]), .spi_wr(spi_wr), .rd_addr(rd_addr),
    .dsm_offset(dsm_offset), .rd_data(rd_data), .own_addr(own_addr),
    .ratio_err(ratio_err), .div_out_true(div_out_true),
    .div_out_comp(div_out_comp));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string s, input logic [23:0] e,
                     input logic [23:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic finish_test();
    if (num_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic do_reset(input logic [2:0] s);
    @(negedge clk);
    reset = 1'b1;
    strap = s;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  // first aligned period may still run on the old ratio, so skip one
  task automatic check_div(input int ep, input int eh);
    int per;
    int hi;
    repeat (2) begin
      while (div_out_true !== 1'b0) @(negedge clk);
      while (div_out_true !== 1'b1) @(negedge clk);
    end
    per = 1;
    hi = 1;
    @(negedge clk);
    while (div_out_true === 1'b1) begin
      per++;
      hi++;
      @(negedge clk);
    end
    while (div_out_true !== 1'b1) begin
      per++;
      @(negedge clk);
    end
    chk("period", 24'(ep), 24'(per));
    chk("high", 24'(eh), 24'(hi));
  endtask
  initial begin
    reset = 1'b1;
    strap = 3'h7;
    dsm_offset = 4'h0;
    do_reset(3'h5);
    host.rd(8'h00, got);
    chk("duty", 24'h4, 24'(got[14:12]));
    host.rd(8'h05, got);
    chk("n_int", 24'h64, got);
    check_div(100, 9);
    host.wr(3'h5, 8'h00, 24'h007000);
    host.wr(3'h5, 8'h05, 24'h000020);
    check_div(32, 15);
    for (int i = 0; i < 5; i++) begin
      host.wr(3'h5, 8'h0a, {23'h0, fe[i]});
      host.wr(3'h5, 8'h05, {4'h0, ni[i]});
      repeat (2) @(negedge clk);
      chk("ratio_err", 24'(er[i]), 24'(ratio_err));
    end
    dsm_offset = 4'h1;
    check_div(37, 15);
    host.wr(3'h2, 8'h09, 24'h000003);
    host.rd(8'h09, got);
    chk("comp other", 24'h0, got);
    host.wr(3'h5, 8'h09, 24'h000003);
    host.rd(8'h09, got);
    chk("comp", 24'h3, got);
    host.wr(3'h3, 8'h02, 24'h000007);
    host.rd(8'h02, got);
    chk("snoop", 24'h7, got);
    host.wr(3'h5, 8'h09, 24'h000005);
    host.wr(3'h3, 8'h02, 24'h000009);
    host.rd(8'h02, got);
    chk("snoop off", 24'h7, got);
    do_reset(3'h2);
    strap = 3'h7;
    repeat (2) @(negedge clk);
    chk("own", 24'h2, 24'(own_addr));
    finish_test();
  end
  initial begin
    #2000000;
    num_errors++;
    finish_test();
  end
endmodule // frac_divider_addr_snoop_tb
`default_nettype wire

//--- verif/serial_host_model.sv
// serial host model issuing decoded writes and register reads
`timescale 1ns/100ps
`default_nettype none
module serial_host_model (
  input  wire logic                 clk,
  output var frac_div_pkg::spi_wr_t spi_wr,
  output logic [7:0]                rd_addr,
  input  wire logic [23:0]          rd_data
);
  initial begin
    spi_wr = '0;
    rd_addr = 8'h00;
  end
  // idle payload inverted so a stale word can never pass for a fresh one
  task automatic wr(input logic [2:0] c, input logic [7:0] a,
                    input logic [23:0] d);
    @(negedge clk);
    spi_wr = '{1'b1, c, a, d};
    @(negedge clk);
    spi_wr = '{1'b0, ~c, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [23:0] d);
    @(negedge clk);
    rd_addr = a;
    @(negedge clk);
    d = rd_data;
  endtask
endmodule // serial_host_model
`default_nettype wire
